// ---- design/regctl_pkg.sv ----
package regctl_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_SWITCHING_MODE = 8'h07;
    localparam logic [7:0] ADDR_RAIL_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_STARTUP_SHUTDOWN = 8'h12;
    localparam logic [7:0] ADDR_VOLTAGE_CHANGE = 8'h20;
    localparam logic [7:0] ADDR_RAMP_RATE = 8'h21;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Field positions
    localparam int SOFTWARE_CONTROL_BIT = 7;
    localparam int MASK_HARD_SHUTDOWN_BIT = 7;
    localparam int BUCK_BOOST_MODE_BIT = 6;
    localparam int NUM_RAILS = 7;
    localparam int NUM_SLEW = 4;
    localparam int NUM_STEP_DOWN = 3;
    localparam int TARGET_WIDTH = 5;
    localparam int RATE_WIDTH = 2;
    localparam logic [7:0] SWITCHING_MODE_MASK = 8'h7f;
    // Ramp step interval in cycles at rate code 3, doubled per lower code
    localparam logic [11:0] RATE_STEP_BASE = 12'h020;

    typedef enum logic [1:0] {
        MODE_PULSE_SKIP = 2'b00,
        MODE_BURST = 2'b01,
        MODE_FORCED_CONT = 2'b10,
        MODE_UNUSED = 2'b11
    } step_mode_t;
endpackage : regctl_pkg

// ---- design/slew_if.sv ----
`timescale 1ns/1ns
interface slew_if;
    logic go;
    logic [4:0] target;
    logic [1:0] rate;
    logic [4:0] ref_value;
    logic done;
    modport ctl(output go, output target, output rate, input ref_value,
        input done);
    modport dac(input go, input target, input rate, output ref_value,
        output done);
endinterface : slew_if

// ---- design/reference_slewer.sv ----
`timescale 1ns/1ns
module reference_slewer
    import regctl_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    slew_if.dac sl
);
    logic [4:0] ref_r;
    logic [11:0] tick_r;
    logic active_r;
    logic done_r;

    // Faster rate codes give shorter step intervals
    function automatic logic [11:0] step_interval(input logic [1:0] code);
        step_interval = RATE_STEP_BASE << (2'd3 - code);
    endfunction : step_interval

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ref_r <= 5'h00;
            tick_r <= 12'h000;
            active_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (sl.go && !active_r && !done_r) begin
                active_r <= 1'b1;
                tick_r <= 12'h000;
            end else if (active_r) begin
                if (ref_r == sl.target) begin
                    active_r <= 1'b0;
                    done_r <= 1'b1;
                end else if (tick_r >= step_interval(sl.rate)) begin
                    tick_r <= 12'h000;
                    // Steps one code at a time either way
                    if (ref_r < sl.target)
                        ref_r <= ref_r + 5'h01;
                    else
                        ref_r <= ref_r - 5'h01;
                end else begin
                    tick_r <= tick_r + 12'h001;
                end
            end
        end
    end

    assign sl.ref_value = ref_r;
    assign sl.done = done_r;
endmodule : reference_slewer

// ---- design/regulator_control_registers.sv ----
`timescale 1ns/1ns
module regulator_control_registers
    import regctl_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port from the serial interface
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Pins
    input wire logic power_on_input,
    input wire logic [6:0] rail_enable_pins,
    input wire logic [6:0] rail_discharged,
    input wire logic power_good_fail_extended,
    // Target words, first and second: ldo2, step3, step2, step1 order
    input wire logic [19:0] target_first,
    input wire logic [19:0] target_second,
    // Regulator controls
    output logic [5:0] step_mode,
    output logic buck_boost_burst,
    output logic [6:0] rail_enable,
    output logic [6:0] discharge_engage,
    output logic hard_shutdown,
    output logic [19:0] reference_value
);
    logic [7:0] switching_mode_control_r;
    logic [7:0] rail_enable_control_r;
    logic [7:0] startup_shutdown_control_r;
    logic [7:0] voltage_change_control_r;
    logic [7:0] ramp_rate_control_r;
    logic [6:0] requested;
    logic [3:0] slew_done;
    logic [5:0] step_mode_nxt;

    function automatic logic [4:0] word_of(input logic [19:0] w,
                                           input int idx);
        word_of = w[idx*TARGET_WIDTH +: TARGET_WIDTH];
    endfunction : word_of

    // Every register write funnels through one decode, so a register
    // added later cannot pick up a subtly different strobe condition
    function automatic logic write_hit(input logic wr,
                                       input logic [7:0] addr,
                                       input logic [7:0] match);
        write_hit = wr && (addr == match);
    endfunction : write_hit

    // ----------------------------------------------------------------
    // Switching mode, startup and ramp rate registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            switching_mode_control_r <= RESET_VALUE;
            startup_shutdown_control_r <= RESET_VALUE;
            ramp_rate_control_r <= RESET_VALUE;
        end else begin
            // Bit 7 has no function and is masked so it always reads zero
            if (write_hit(reg_wr, reg_addr, ADDR_SWITCHING_MODE))
                switching_mode_control_r <=
                    reg_wdata & SWITCHING_MODE_MASK;
            if (write_hit(reg_wr, reg_addr, ADDR_STARTUP_SHUTDOWN))
                startup_shutdown_control_r <= reg_wdata;
            if (write_hit(reg_wr, reg_addr, ADDR_RAMP_RATE))
                ramp_rate_control_r <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // Enable register, cleared while power-on pin is low
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || !power_on_input)
            rail_enable_control_r <= RESET_VALUE;
        else if (write_hit(reg_wr, reg_addr, ADDR_RAIL_ENABLE))
            rail_enable_control_r <= reg_wdata;
    end

    // ----------------------------------------------------------------
    // Voltage change: go bits set by host, cleared on completion
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            voltage_change_control_r <= RESET_VALUE;
        end else begin
            for (int i = 0; i < NUM_SLEW; i++) begin
                // A fresh go write wins over a same-cycle completion
                // The slewer sees a go bit one cycle after the write lands
                if (write_hit(reg_wr, reg_addr, ADDR_VOLTAGE_CHANGE)) begin
                    voltage_change_control_r[2*i] <= reg_wdata[2*i];
                    voltage_change_control_r[2*i+1] <= reg_wdata[2*i+1];
                end else if (slew_done[i]) begin
                    voltage_change_control_r[2*i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Slewing references
    // ----------------------------------------------------------------
    // Select bits are read live: a select change mid-slew retargets it
    for (genvar g = 0; g < NUM_SLEW; g++) begin : g_slew
        slew_if sl();
        assign sl.go = voltage_change_control_r[2*g];
        assign sl.target = voltage_change_control_r[2*g+1] ?
            word_of(target_second, g) : word_of(target_first, g);
        assign sl.rate = ramp_rate_control_r[g*RATE_WIDTH +: RATE_WIDTH];
        assign slew_done[g] = sl.done;
        assign reference_value[g*TARGET_WIDTH +: TARGET_WIDTH] =
            sl.ref_value;
        reference_slewer u_slewer (
            .clk_sys(clk_sys),
            .rst(rst),
            .sl(sl)
        );
    end

    // ----------------------------------------------------------------
    // Regulator controls
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_STEP_DOWN; i++) begin
            // Unused code leaves the previous mode in force
            if (switching_mode_control_r[2*i +: 2] == MODE_UNUSED)
                step_mode_nxt[2*i +: 2] = step_mode[2*i +: 2];
            else
                step_mode_nxt[2*i +: 2] =
                    switching_mode_control_r[2*i +: 2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_mode <= 6'h00;
            buck_boost_burst <= 1'b0;
        end else begin
            step_mode <= step_mode_nxt;
            buck_boost_burst <=
                switching_mode_control_r[BUCK_BOOST_MODE_BIT];
        end
    end

    always_comb begin
        if (rail_enable_control_r[SOFTWARE_CONTROL_BIT])
            requested = rail_enable_control_r[6:0];
        else
            requested = rail_enable_control_r[6:0] | rail_enable_pins;
    end

    // ----------------------------------------------------------------
    // Rail enables
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rail_enable <= 7'h00;
        end else begin
            for (int i = 0; i < NUM_RAILS; i++) begin
                // Waiting rails hold off until discharged below 300mV
                if (startup_shutdown_control_r[i])
                    rail_enable[i] <= requested[i];
                else
                    rail_enable[i] <= requested[i] &
                        (rail_enable[i] | rail_discharged[i]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Discharge resistors
    // ----------------------------------------------------------------
    // Immediate-start rails never engage the resistor, even when off
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            discharge_engage <= 7'h00;
        end else begin
            for (int i = 0; i < NUM_RAILS; i++)
                discharge_engage[i] <= !startup_shutdown_control_r[i] &&
                    !requested[i];
        end
    end

    // ----------------------------------------------------------------
    // Power-good hard shutdown
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst)
            hard_shutdown <= 1'b0;
        else
            hard_shutdown <= power_good_fail_extended &
                !startup_shutdown_control_r[MASK_HARD_SHUTDOWN_BIT];
    end

    // ----------------------------------------------------------------
    // Read-back
    // ----------------------------------------------------------------
    // Combinational so the serial side can fetch in the addressed cycle
    always_comb begin
        unique case (reg_addr)
            ADDR_SWITCHING_MODE: reg_rdata = switching_mode_control_r;
            ADDR_RAIL_ENABLE: reg_rdata = rail_enable_control_r;
            ADDR_STARTUP_SHUTDOWN: reg_rdata = startup_shutdown_control_r;
            ADDR_VOLTAGE_CHANGE: reg_rdata = voltage_change_control_r;
            ADDR_RAMP_RATE: reg_rdata = ramp_rate_control_r;
            default: reg_rdata = RESET_VALUE;
        endcase
    end
endmodule : regulator_control_registers

// ---- dv/regctl_checker.sv ----
`timescale 1ns/1ns
module regctl_checker
    import regctl_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic power_on_input,
    input wire logic [6:0] rail_enable_pins,
    input wire logic [6:0] rail_discharged,
    input wire logic power_good_fail_extended,
    // Controls
    input wire logic [5:0] step_mode,
    input wire logic buck_boost_burst,
    input wire logic [6:0] rail_enable,
    input wire logic hard_shutdown,
    input wire logic [19:0] reference_value
);
    logic [7:0] en_r;
    logic [7:0] sd_r;
    logic rst_d_r;
    // Shadows of the enable and start-up registers, seen from the writes
    always_ff @(posedge clk_sys) begin
        if (rst || !power_on_input) en_r <= 8'h00;
        else if (reg_wr && reg_addr == ADDR_RAIL_ENABLE) en_r <= reg_wdata;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) sd_r <= 8'h00;
        else if (reg_wr && reg_addr == ADDR_STARTUP_SHUTDOWN)
            sd_r <= reg_wdata;
    end
    always_ff @(posedge clk_sys) begin
        rst_d_r <= rst;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_mode_wr;
        reg_wr && reg_addr == ADDR_SWITCHING_MODE;
    endsequence
    property p_mode;
        s_mode_wr ##0 reg_wdata[1:0] != 2'b11
            |-> ##2 step_mode[1:0] == $past(reg_wdata[1:0], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("step mode wrong");
    property p_bb;
        s_mode_wr |-> ##2 buck_boost_burst == $past(reg_wdata[6], 2);
    endproperty
    a_bb: assert property (p_bb) else $error("buck-boost mode wrong");
    property p_unmap;
        !(reg_addr inside {8'h07, 8'h10, 8'h12, 8'h20, 8'h21})
            |-> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_hard;
        power_good_fail_extended |=> hard_shutdown == !$past(sd_r[7]);
    endproperty
    a_hard: assert property (p_hard) else $error("shutdown wrong");
    property p_sw;
        en_r[7] && sd_r[6:0] == 7'h7f |=> rail_enable == $past(en_r[6:0]);
    endproperty
    a_sw: assert property (p_sw) else $error("software enable wrong");
    property p_or;
        !en_r[7] && sd_r[6:0] == 7'h7f
            |=> rail_enable == $past(en_r[6:0] | rail_enable_pins);
    endproperty
    a_or: assert property (p_or) else $error("pin enable wrong");
    property p_wait;
        1'b1 |=> (rail_enable & ~$past(rail_enable)
            & ~$past(sd_r[6:0] | rail_discharged)) == 7'h00;
    endproperty
    a_wait: assert property (p_wait) else $error("early enable");
    property p_rst;
        $fell(rst) |-> rail_enable == 7'h00 && step_mode == 6'h00
            && !hard_shutdown && reference_value == 20'h00000;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_ramp;
        !rst_d_r && $changed(reference_value[4:0])
            |-> reference_value[4:0] - $past(reference_value[4:0])
            inside {5'h01, 5'h1f};
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp jump");
endmodule : regctl_checker
bind regulator_control_registers regctl_checker i_regctl_checker(
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .power_on_input(power_on_input),
    .rail_enable_pins(rail_enable_pins),
    .rail_discharged(rail_discharged),
    .power_good_fail_extended(power_good_fail_extended),
    .step_mode(step_mode),
    .buck_boost_burst(buck_boost_burst),
    .rail_enable(rail_enable),
    .hard_shutdown(hard_shutdown),
    .reference_value(reference_value)
);

// ---- dv/host_model.sv ----
`timescale 1ns/1ns
module host_model (
    // Register port
    input wire logic clk_sys,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Released data shows the inverse, so no stale byte can pass as fresh
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    task automatic sel(input logic [7:0] a);
        @(negedge clk_sys);
        reg_addr = a;
    endtask : sel
endmodule : host_model

// ---- dv/regulator_control_registers_bench.sv ----
`timescale 1ns/1ns
module regulator_control_registers_bench;
    typedef struct {logic [2:0] k; logic [19:0] e;} note_t;
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr, buck_boost_burst, hard_shutdown;
    logic power_on_input = 1'b1, power_good_fail_extended = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] rail_enable_pins = 7'h00, rail_discharged = 7'h00;
    logic [6:0] rail_enable, discharge_engage, e;
    logic [19:0] target_first = 20'h0, target_second = 20'h0, reference_value;
    logic [5:0] step_mode;
    logic [1:0] m;
    logic samp = 1'b0;
    note_t q[$];
    note_t n;
    int err_total = 0, tests_run = 0, cyc = 0, r;
    logic [7:0] adr[6] = '{8'h07, 8'h10, 8'h12, 8'h20, 8'h21, 8'h55};
    always #4 clk_sys = ~clk_sys;
    host_model i_host_model(
        .clk_sys(clk_sys),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata)
    );
    regulator_control_registers i_regulator_control_registers(
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .power_on_input(power_on_input),
        .rail_enable_pins(rail_enable_pins),
        .rail_discharged(rail_discharged),
        .power_good_fail_extended(power_good_fail_extended),
        .target_first(target_first),
        .target_second(target_second),
        .step_mode(step_mode),
        .buck_boost_burst(buck_boost_burst),
        .rail_enable(rail_enable),
        .discharge_engage(discharge_engage),
        .hard_shutdown(hard_shutdown),
        .reference_value(reference_value)
    );
    task automatic cmp(string nm, logic [19:0] ex, logic [19:0] got);
        tests_run++;
        if (got !== ex) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp
    task conclude;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [2:0] k, input logic [19:0] ex);
        @(negedge clk_sys);
        q.push_back('{k, ex});
        samp = 1'b1;
        @(negedge clk_sys);
        samp = 1'b0;
    endtask : chk
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 6000) begin
            err_total++;
            conclude();
        end else if (samp) begin
            n = q.pop_front();
            case (n.k)
                3'h0: cmp("reg_rdata", n.e, {12'h000, reg_rdata});
                3'h1: cmp("rail_enable", n.e, {13'h0000, rail_enable});
                3'h2: cmp("step_mode", n.e, {14'h0000, step_mode});
                3'h3: cmp("hard_shutdown", n.e, {19'h00000, hard_shutdown});
                3'h5: cmp("discharge_engage", n.e,
                    {13'h0000, discharge_engage});
                3'h6: cmp("buck_boost_burst", n.e,
                    {19'h00000, buck_boost_burst});
                default: cmp("reference_value", n.e, reference_value);
            endcase
        end
    end
    initial begin
        r = $urandom(26862);
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            i_host_model.sel(adr[i]);
            chk(3'h0, 20'h0);
        end
        for (int i = 0; i < 3; i++) begin
            m = 2'(i);
            i_host_model.wr(8'h07, {1'b1, m[0], m, m, m});
            chk(3'h0, {13'h0, m[0], m, m, m});
            chk(3'h2, {14'h0, m, m, m});
            chk(3'h6, {19'h0, m[0]});
        end
        i_host_model.wr(8'h07, 8'h3f);
        chk(3'h2, 20'h0002a);
        i_host_model.wr(8'h12, 8'h7f);
        chk(3'h5, 20'h0);
        rail_enable_pins = 7'($urandom);
        e = 7'($urandom);
        i_host_model.wr(8'h10, {1'b0, e});
        chk(3'h1, {13'h0, rail_enable_pins | e});
        i_host_model.wr(8'h10, {1'b1, e});
        chk(3'h1, {13'h0, e});
        power_on_input = 1'b0;
        @(negedge clk_sys) power_on_input = 1'b1;
        i_host_model.sel(8'h10);
        chk(3'h0, 20'h0);
        power_good_fail_extended = 1'b1;
        i_host_model.wr(8'h12, 8'hff);
        chk(3'h3, 20'h0);
        i_host_model.wr(8'h12, 8'h7f);
        chk(3'h3, 20'h1);
        i_host_model.wr(8'h12, 8'h00);
        i_host_model.wr(8'h10, 8'h80);
        chk(3'h5, 20'h7f);
        i_host_model.wr(8'h10, 8'hff);
        chk(3'h1, 20'h0);
        rail_discharged = 7'h7f;
        chk(3'h1, 20'h7f);
        // Odd fields keep every slew at least one step long
        target_first = 20'($urandom) | 20'h08421;
        target_second = target_first ^ (20'($urandom) | 20'h08421);
        i_host_model.wr(8'h21, 8'hff);
        i_host_model.wr(8'h20, 8'h55);
        i_host_model.sel(8'h20);
        chk(3'h0, 20'h55);
        repeat (1100) @(negedge clk_sys);
        chk(3'h4, target_first);
        chk(3'h0, 20'h0);
        i_host_model.wr(8'h20, 8'hff);
        repeat (1100) @(negedge clk_sys);
        chk(3'h4, target_second);
        chk(3'h0, 20'haa);
        // Rate codes 3, 2, 1, 0 on words 0 to 3: each single step lands
        // about 34, 66, 130 and 258 cycles after the go write
        target_first = target_second ^ 20'h08421;
        i_host_model.wr(8'h21, 8'h1b);
        i_host_model.wr(8'h20, 8'h55);
        repeat (95) @(negedge clk_sys);
        chk(3'h4, {target_second[19:10], target_first[9:0]});
        repeat (200) @(negedge clk_sys);
        chk(3'h4, target_first);
        chk(3'h0, 20'h0);
        conclude();
    end
endmodule : regulator_control_registers_bench
